// file: iwtc_ctrl.sv
// instruction watch trap control register and its show/trap decode
`timescale 1ns/10ps
// What this block does
// - bits 20 to 23 enable a software trap on a match of watchpoints 0 to 3, cleared on reset.
// - bits 24 to 27 show the port trap enables read-only, zero after reset.
// - bit 28 set makes the first instruction breakpoint hit be ignored, data side untouched.
// - a new bits 29 to 31 value acts from the register write instruction itself on.
// - a zero ordering bit keeps the core fully serialized under each of the four show codes.
// - show code 00 gives a show cycle for every fetch and is the reset value with ordering zero.
// - show code 01 gives show cycles only at direct or indirect flow changes.
// - show code 10 gives show cycles only at indirect flow changes.
// - show code 11 gives no fetch show cycles while the core stays serialized.
module iwtc_ctrl import iwtc_pkg::*; #(
	parameter int NUM_WATCH = IWTC_NUM_WATCH
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	// special-register access from the core
	input wire logic spr_wr,
	input wire logic [31:0] spr_wdata,
	output logic [31:0] spr_rdata,
	// development port side
	input wire logic port_en_wr,
	input wire logic [NUM_WATCH-1:0] port_en_wdata,
	// watchpoint matches and trap requests
	input wire logic [NUM_WATCH-1:0] watch_match,
	input wire logic bp_match,
	output logic [NUM_WATCH-1:0] sw_trap,
	output logic [NUM_WATCH-1:0] port_trap,
	output logic bp_hit,
	// fetch stream and show-cycle requests
	input wire iwtc_fetch_t fetch,
	output logic show_cycle,
	output logic serialize
);
	iwtc_state_t st_r;
	iwtc_state_t st_nxt;
	iwtc_show_t wr_show;
	iwtc_show_t eff_show;
	logic eff_order;

	// the written code is forwarded so the write instruction itself obeys it
	always_comb begin
		wr_show = iwtc_show_t'({spr_wdata[iwtc_bit(IWTC_SHOW_LO)],
			spr_wdata[iwtc_bit(IWTC_SHOW_LO + 1)]});
		// a write dropped by a low clock enable must not be forwarded either
		eff_show = (spr_wr & clk_en) ? wr_show
			: st_r.fetch_show_select;
		eff_order = (spr_wr & clk_en) ? spr_wdata[iwtc_bit(IWTC_ORDER_BIT)]
			: st_r.core_ordering_ctrl;
	end

	// every defined code keeps the core serialized while ordering is zero
	assign serialize = ~eff_order;

	always_comb begin
		show_cycle = 1'b0;
		case (eff_show)
			IWTC_SHOW_ALL: begin
				show_cycle = fetch.valid;
			end
			IWTC_SHOW_FLOW: begin
				show_cycle = fetch.valid & fetch.flow_change;
			end
			IWTC_SHOW_INDIRECT: begin
				show_cycle = fetch.valid & fetch.flow_change
					& fetch.indirect;
			end
			IWTC_SHOW_NONE: begin
				show_cycle = 1'b0;
			end
			default: begin
				show_cycle = 1'b0;
			end
		endcase
	end

	// skip mode swallows the first breakpoint hit after it is armed
	assign bp_hit = bp_match & (~st_r.skip_first_hit | (|st_r.first_seen));

	genvar g;
	generate
		for (g = 0; g < NUM_WATCH; g++) begin : g_trap
			assign sw_trap[g] = watch_match[g] & st_r.sw_trap_en[g];
			assign port_trap[g] = watch_match[g] & st_r.port_trap_en[g];
			assign spr_rdata[iwtc_bit(IWTC_SW_EN_LO + g)] = st_r.sw_trap_en[g];
			assign spr_rdata[iwtc_bit(IWTC_PORT_EN_LO + g)] =
				st_r.port_trap_en[g];
		end
	endgenerate

	// bits 0 to 19 belong to other logic and read as zero here
	assign spr_rdata[31:12] = 20'h00000;
	assign spr_rdata[iwtc_bit(IWTC_SKIP_BIT)] = st_r.skip_first_hit;
	assign spr_rdata[iwtc_bit(IWTC_ORDER_BIT)] = st_r.core_ordering_ctrl;
	assign spr_rdata[iwtc_bit(IWTC_SHOW_LO)] = st_r.fetch_show_select[1];
	assign spr_rdata[iwtc_bit(IWTC_SHOW_LO + 1)] = st_r.fetch_show_select[0];

	always_comb begin
		st_nxt = st_r;
		if (bp_match) begin
			st_nxt.first_seen = 4'h1;
		end
		if (spr_wr) begin
			for (int i = 0; i < NUM_WATCH; i++) begin
				st_nxt.sw_trap_en[i] =
					spr_wdata[iwtc_bit(IWTC_SW_EN_LO + i)];
			end
			st_nxt.skip_first_hit = spr_wdata[iwtc_bit(IWTC_SKIP_BIT)];
			// rewriting the register re-arms the first-hit skip
			st_nxt.first_seen = 4'h0;
			st_nxt.core_ordering_ctrl = eff_order;
			st_nxt.fetch_show_select = wr_show;
		end
		// only the development port reaches these bits
		if (port_en_wr) begin
			st_nxt.port_trap_en = port_en_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_r <= '{sw_trap_en: IWTC_SW_EN_RST,
				port_trap_en: IWTC_PORT_EN_RST,
				skip_first_hit: IWTC_SKIP_RST,
				core_ordering_ctrl: IWTC_ORDER_RST,
				fetch_show_select: IWTC_SHOW_ALL,
				first_seen: 4'h0};
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end
endmodule : iwtc_ctrl

// file: iwtc_pkg.sv
// package for the instruction watch trap control block
package iwtc_pkg;
	localparam int IWTC_NUM_WATCH = 4;
	// bit positions use big-endian numbering: bit 0 is the msb of the word
	localparam int IWTC_SW_EN_LO = 20;
	localparam int IWTC_PORT_EN_LO = 24;
	localparam int IWTC_SKIP_BIT = 28;
	localparam int IWTC_ORDER_BIT = 29;
	localparam int IWTC_SHOW_LO = 30;
	localparam logic [3:0] IWTC_SW_EN_RST = 4'h0;
	localparam logic [3:0] IWTC_PORT_EN_RST = 4'h0;
	localparam logic IWTC_SKIP_RST = 1'b0;
	localparam logic IWTC_ORDER_RST = 1'b0;

	typedef enum logic [1:0] {
		IWTC_SHOW_ALL = 2'h0,
		IWTC_SHOW_FLOW = 2'h1,
		IWTC_SHOW_INDIRECT = 2'h2,
		IWTC_SHOW_NONE = 2'h3
	} iwtc_show_t;

	typedef struct packed {
		logic [3:0] sw_trap_en;
		logic [3:0] port_trap_en;
		logic skip_first_hit;
		logic core_ordering_ctrl;
		iwtc_show_t fetch_show_select;
		logic [3:0] first_seen;
	} iwtc_state_t;

	// one retired instruction fetch as seen by the show-cycle logic
	typedef struct packed {
		logic valid;
		logic flow_change;
		logic indirect;
	} iwtc_fetch_t;

	// msb-0 bit n of a 32-bit word maps to lsb-0 index 31-n
	function automatic int iwtc_bit(input int n);
		return 31 - n;
	endfunction : iwtc_bit
endpackage : iwtc_pkg

// file: iwtc_props.sv
// assertions on the watch trap control ports
`timescale 1ns/10ps
module iwtc_props import iwtc_pkg::*; #(parameter int NUM_WATCH = 4) (
	input wire logic clock, srst, clk_en, spr_wr, port_en_wr, bp_match,
	input wire logic bp_hit, show_cycle, serialize,
	input wire logic [31:0] spr_wdata, spr_rdata,
	input wire logic [NUM_WATCH-1:0] port_en_wdata, watch_match,
	input wire logic [NUM_WATCH-1:0] sw_trap, port_trap,
	input wire iwtc_fetch_t fetch
);
	logic w;
	logic [1:0] c;
	logic [3:0] se, pe;
	assign w = spr_wr & clk_en;
	// a write forwards its show code into its own cycle
	assign c = w ? spr_wdata[1:0] : spr_rdata[1:0];
	assign se = {spr_rdata[8], spr_rdata[9], spr_rdata[10], spr_rdata[11]};
	assign pe = {spr_rdata[4], spr_rdata[5], spr_rdata[6], spr_rdata[7]};
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	chk_sw_trap: assert property (sw_trap == (watch_match & se))
		else $error("sw trap");
	chk_port_trap: assert property (port_trap == (watch_match & pe))
		else $error("port trap");
	chk_port_load: assert property (port_en_wr && clk_en |=>
		pe == $past(port_en_wdata)) else $error("port load");
	chk_port_keep: assert property (
		!$past(port_en_wr) && !$past(srst) |-> $stable(pe)) else $error("keep");
	chk_sw_load: assert property (w |=>
		(spr_rdata & 32'hffffff0f) == ($past(spr_wdata) & 32'h00000f0f))
		else $error("sw load");
	chk_serial: assert property (
		serialize == !(w ? spr_wdata[2] : spr_rdata[2])) else $error("serial");
	chk_show_code: assert property (show_cycle == (fetch.valid &&
		(c == 2'h0 || c == 2'h1 && fetch.flow_change ||
		c == 2'h2 && fetch.flow_change && fetch.indirect)))
		else $error("show cycle");
	chk_skip_first: assert property ($past(w) && spr_rdata[3] |-> !bp_hit)
		else $error("skip first");
endmodule : iwtc_props
bind iwtc_ctrl iwtc_props #(.NUM_WATCH(NUM_WATCH)) i_iwtc_props (.*);

// file: iwtc_dev_tool.sv
// development tool model that loads the port trap enables
`timescale 1ns/10ps
module iwtc_dev_tool (
	input wire logic clock, req,
	input wire logic [3:0] val,
	output logic port_en_wr = 1'b0,
	output logic [3:0] port_en_wdata = 4'h0
);
	// idle data toggles so a stale value never passes for a load
	always @(negedge clock) begin
		port_en_wr <= req;
		port_en_wdata <= req ? val : ~port_en_wdata;
	end
endmodule : iwtc_dev_tool

// file: tb_top.sv
// testbench for the watch trap control block
`timescale 1ns/10ps
module tb_top;
	import iwtc_pkg::*;
	logic clock = 1'b0, srst = 1'b1, clk_en = 1'b1, spr_wr = 1'b0;
	logic bp_match = 1'b0, req = 1'b0, port_en_wr, bp_hit, show_cycle, serialize;
	logic [31:0] spr_wdata = 32'h0, spr_rdata;
	logic [3:0] watch_match = 4'h0, val = 4'h9, sw_trap, port_trap, pd;
	iwtc_fetch_t fetch = 3'h0;
	int err_count = 0, n_tests = 0, cyc = 0;
	logic [2:0] tbl [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
	always #20 clock = ~clock;
	iwtc_dev_tool i_iwtc_dev_tool (.clock, .req, .val, .port_en_wr,
		.port_en_wdata(pd));
	iwtc_ctrl i_iwtc_ctrl (.clock, .srst, .clk_en, .spr_wr, .spr_wdata,
		.spr_rdata, .port_en_wr, .port_en_wdata(pd), .watch_match, .bp_match,
		.sw_trap, .port_trap, .bp_hit, .fetch, .show_cycle, .serialize);
	task automatic chk(input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [31:0] d);
		spr_wr = 1'b1;
		spr_wdata = d;
		@(negedge clock) spr_wr = 1'b0;
	endtask : wr
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : wrap_up
	always @(posedge clock) if (++cyc == 2000) begin
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (12) @(negedge clock);
		srst = 1'b0;
		fetch = 3'h4;
		#1 chk(spr_rdata, 32'h0);
		chk({serialize, show_cycle}, 2'h3);
		wr(32'hffffffff);
		chk(spr_rdata, 32'h00000f0f);
		req <= 1'b1;
		@(negedge clock) req <= 1'b0;
		repeat (2) @(negedge clock);
		watch_match = 4'h3;
		#1 chk(spr_rdata, 32'h00000f9f);
		chk({sw_trap, port_trap}, 8'h31);
		wr(32'h00000008);
		bp_match = 1'b1;
		#1 chk(bp_hit, 1'b0);
		@(negedge clock) #1 chk(bp_hit, 1'b1);
		bp_match = 1'b0;
		spr_wr = 1'b1;
		for (int c = 0; c < 4; c++) begin
			spr_wdata = 32'(c);
			for (int f = 0; f < 3; f++) begin
				fetch = f == 0 ? 3'h4 : f == 1 ? 3'h6 : 3'h7;
				#1 chk(show_cycle, tbl[c][2-f]);
			end
			chk(serialize, 1'b1);
			@(negedge clock);
		end
		// write held up while the clock enable is low must be dropped
		clk_en = 1'b0;
		spr_wdata = 32'h00000004;
		#1 chk(serialize, 1'b1);
		@(negedge clock) spr_wr = 1'b0;
		clk_en = 1'b1;
		#1 chk(spr_rdata, 32'h00000093);
		wrap_up();
	end
endmodule : tb_top
